// ---- logic/lss_fault_qual.sv ----
`timescale 1ns/1ps
module lss_fault_qual #(
  parameter int SENSE_CYC = 200,
  parameter int REFRESH_CYC = 4000
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic drive_on,
  input wire logic short_raw,
  input wire logic open_raw,
  input wire logic ol_on_en,
  output logic fault_qual,
  output logic gate_off
);
  localparam int MAXC = (SENSE_CYC > REFRESH_CYC) ? SENSE_CYC : REFRESH_CYC;
  localparam int CW = $clog2(MAXC + 1);
  if (SENSE_CYC < 1 || REFRESH_CYC < 1) begin : g_bad
    $error("lss_fault_qual needs counts of one cycle or more");
  end
  logic [CW-1:0] cnt_ff;
  logic fault_ff;
  logic gate_ff;
  logic cond;

  // Short and on-state open load while on, open load while off
  assign cond = drive_on ? (short_raw | (ol_on_en & open_raw)) : open_raw;
  assign fault_qual = fault_ff;
  assign gate_off = gate_ff;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cnt_ff <= '0;
      fault_ff <= 1'b0;
      gate_ff <= 1'b0;
    end
    else if (gate_ff)
    begin
      // Retry wait with the switch held off
      fault_ff <= 1'b0;
      if (!drive_on || cnt_ff == CW'(REFRESH_CYC - 1))
      begin
        gate_ff <= 1'b0;
        cnt_ff <= '0;
      end
      else
      begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
    else if (!cond)
    begin
      cnt_ff <= '0;
      fault_ff <= 1'b0;
    end
    else if (cnt_ff == CW'(SENSE_CYC - 1))
    begin
      fault_ff <= 1'b1;
      cnt_ff <= '0;
      gate_ff <= drive_on & short_raw;
    end
    else
    begin
      fault_ff <= 1'b0;
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
endmodule : lss_fault_qual

// ---- logic/lss_fifo.sv ----
`timescale 1ns/1ps
module lss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("lss_fifo needs DEPTH of 2 or more and WIDTH of 1 or more");
  end
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    ptr_next = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_next

  assign in_ready = (cnt_ff != (AW + 1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ff <= ptr_next(wr_ff);
      end
      if (pop)
      begin
        rd_ff <= ptr_next(rd_ff);
      end
      if (push && !pop)
      begin
        cnt_ff <= cnt_ff + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule : lss_fifo

// ---- logic/lss_pkg.sv ----
package lss_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_SENSE_NS = 20000;
  localparam int T_SENSE_CYC = (T_SENSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_REFRESH_NS = 400000;
  localparam int T_REFRESH_CYC = (T_REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NUM_OUT = 8;
  localparam int NUM_SER = 6;
  localparam int BYTE_W = 8;
  localparam int CMD_FIFO_DEPTH = 16;
  localparam int MSB_POS = 7;
  localparam logic [7:0] FAULT_NONE = 8'h00;
  localparam logic [7:0] CMD_CLEAR = 8'h00;
  localparam logic [27:0] PINS_RESET = 28'h800_0000;
  typedef struct packed {
    logic [1:0] ol_on_en;
    logic [5:0] chan;
  } lss_cmd_t;
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic si;
    logic mode_ovr;
    logic [7:0] pins;
    logic [7:0] short_sense;
    logic [7:0] open_sense;
  } lss_pins_t;
  typedef enum logic {
    LSS_IDLE,
    LSS_SEL
  } lss_spi_st_t;
endpackage : lss_pkg

// ---- logic/lss_spi_switch.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Outputs 0-5 turn on when serial bit or parallel pin is high.
// - Outputs 6 and 7 follow only their own parallel pins.
// - Command and status bits travel most significant bit first.
// - Last six bits of a command byte switch the six serial outputs.
// - Select rising queues the latest received command for the latch.
// - Reset clears the serial command so serial outputs start off.
// - Status bits read one for a faulted output, zero otherwise.
// - Sixteen-bit transfer returns status, then the first byte received.
// - After sixteen bits only the second byte becomes the command.
// - Fault register is frozen while select is low.
// - Serial output changes on falling clock; receiver samples on rising.
// - Select high releases serial output and reopens fault capture.
// - 32-bit transfer returns status, then the first three bytes received.
// - Override high ignores serial and parallel 6-7, releases serial output.
// - Override high makes outputs 0-5 follow parallel pins 0-5 pairwise.
// - Serial commands still accepted under override, applied once it drops.
// - Shorts sensed while on, opens while off; bits 6-7 add on-state opens for outputs 0-5.
// - Fault bits stay set until read out over the serial port.
// - A shorted output retries at low duty until short clears or command off.
// - Faults count only after persisting for the sense time.
// - Command bits 5 down to 0 drive channels 5 down to 0.
// - Status most significant bit is output 7, down to output 0.
// - Override high forces outputs 6 and 7 off.
module lss_spi_switch
  import lss_pkg::*;
#(
  parameter int SENSE_CYC = T_SENSE_CYC,
  parameter int REFRESH_CYC = T_REFRESH_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic mode_ovr,
  input wire logic [7:0] parallel_input_pins,
  input wire logic [7:0] short_sense,
  input wire logic [7:0] open_sense,
  output logic [5:0] high_power_outputs,
  output logic [1:0] low_power_outputs,
  output logic so,
  output logic so_oe_n,
  output logic [7:0] fault_status
);
  if (SENSE_CYC < 1 || REFRESH_CYC < 1) begin : g_bad
    $error("lss_spi_switch needs counts of one cycle or more");
  end
  lss_pins_t raw;
  lss_pins_t s1_ff;
  lss_pins_t s2_ff;
  lss_pins_t s3_ff;
  lss_pins_t pin_ff;
  logic sclk_prev_ff;
  logic cs_prev_ff;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic mode_f;
  logic [7:0] par_pins;
  lss_spi_st_t st_ff;
  lss_spi_st_t nxt_st;
  logic [7:0] shreg_ff;
  logic in_bit_ff;
  logic pend_ff;
  logic so_ff;
  logic so_oe_n_ff;
  logic [7:0] rx_word;
  lss_cmd_t hold_cmd_ff;
  logic hold_v_ff;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  lss_cmd_t fifo_out;
  lss_cmd_t cmd_ff;
  logic [7:0] fault_ff;
  logic [7:0] qual;
  logic [7:0] gate_off;
  logic [7:0] drive_on;
  logic [5:0] hp_ff;
  logic [1:0] lp_ff;
  assign raw = '{cs_n: cs_n, sclk: sclk, si: si, mode_ovr: mode_ovr,
                 pins: parallel_input_pins, short_sense: short_sense,
                 open_sense: open_sense};
  // Three-stage synchronisers, value changes once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s1_ff <= PINS_RESET;
      s2_ff <= PINS_RESET;
      s3_ff <= PINS_RESET;
      pin_ff <= PINS_RESET;
    end
    else
    begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pin_ff <= (s3_ff & ~(s2_ff ^ s3_ff)) | (pin_ff & (s2_ff ^ s3_ff));
    end
  end
  assign mode_f = pin_ff.mode_ovr;
  assign par_pins = pin_ff.pins;
  // Edge detection on the filtered link clock and select
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sclk_prev_ff <= 1'b0;
      cs_prev_ff <= 1'b1;
    end
    else
    begin
      sclk_prev_ff <= pin_ff.sclk;
      cs_prev_ff <= pin_ff.cs_n;
    end
  end
  assign sclk_rise = pin_ff.sclk & ~sclk_prev_ff;
  assign sclk_fall = ~pin_ff.sclk & sclk_prev_ff;
  assign cs_fall = ~pin_ff.cs_n & cs_prev_ff;
  assign cs_rise = pin_ff.cs_n & ~cs_prev_ff;
  // Transfer sequencing
  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      LSS_IDLE:
      begin
        if (cs_fall)
        begin
          nxt_st = LSS_SEL;
        end
      end
      LSS_SEL:
      begin
        if (cs_rise)
        begin
          nxt_st = LSS_IDLE;
        end
      end
      default:
      begin
        nxt_st = LSS_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_ff <= LSS_IDLE;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
  // Shift register: status loaded at select, received bits fed behind it
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      shreg_ff <= FAULT_NONE;
      in_bit_ff <= 1'b0;
      pend_ff <= 1'b0;
    end
    else if (st_ff == LSS_IDLE)
    begin
      pend_ff <= 1'b0;
      if (cs_fall)
      begin
        shreg_ff <= fault_ff;
      end
    end
    else if (sclk_rise)
    begin
      in_bit_ff <= pin_ff.si;
      pend_ff <= 1'b1;
    end
    else if (sclk_fall && pend_ff)
    begin
      shreg_ff <= {shreg_ff[6:0], in_bit_ff};
      pend_ff <= 1'b0;
    end
  end
  // Last eight bits received, including one not yet shifted
  assign rx_word = pend_ff ? {shreg_ff[6:0], in_bit_ff} : shreg_ff;
  // Serial output: moves on falling clock, released when idle or overridden
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      so_ff <= 1'b0;
      so_oe_n_ff <= 1'b1;
    end
    else
    begin
      so_oe_n_ff <= (nxt_st == LSS_IDLE) | mode_f;
      if (st_ff == LSS_IDLE && cs_fall)
      begin
        so_ff <= fault_ff[MSB_POS];
      end
      else if (st_ff == LSS_SEL && sclk_fall && pend_ff)
      begin
        so_ff <= shreg_ff[MSB_POS - 1];
      end
    end
  end

  // Holding stage in front of the command queue, newest command wins
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      hold_cmd_ff <= CMD_CLEAR;
      hold_v_ff <= 1'b0;
    end
    else if (st_ff == LSS_SEL && cs_rise)
    begin
      hold_cmd_ff <= rx_word;
      hold_v_ff <= 1'b1;
    end
    else if (hold_v_ff && fifo_in_ready)
    begin
      hold_v_ff <= 1'b0;
    end
  end

  // Queue drains only while override is low
  assign fifo_out_ready = ~mode_f;

  lss_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(CMD_FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(hold_v_ff),
    .in_ready(fifo_in_ready),
    .in_data(hold_cmd_ff),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );

  // Output command latch
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cmd_ff <= CMD_CLEAR;
    end
    else if (fifo_out_valid && fifo_out_ready)
    begin
      cmd_ff <= fifo_out;
    end
  end

  // Requested channel states
  always_comb
  begin
    if (mode_f)
    begin
      drive_on[5:0] = par_pins[5:0];
      drive_on[7:6] = 2'h0;
    end
    else
    begin
      drive_on[5:0] = cmd_ff.chan | par_pins[5:0];
      drive_on[7:6] = par_pins[7:6];
    end
  end

  // Per-channel fault qualification and short retry
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_chan
    lss_fault_qual #(
      .SENSE_CYC(SENSE_CYC),
      .REFRESH_CYC(REFRESH_CYC)
    ) u_qual (
      .clk(clk),
      .reset_n(reset_n),
      .drive_on(drive_on[i]),
      .short_raw(pin_ff.short_sense[i]),
      .open_raw(pin_ff.open_sense[i]),
      .ol_on_en((i < NUM_SER) ? (|cmd_ff.ol_on_en) : 1'b0),
      .fault_qual(qual[i]),
      .gate_off(gate_off[i])
    );
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      hp_ff <= 6'h00;
      lp_ff <= 2'h0;
    end
    else
    begin
      hp_ff <= drive_on[5:0] & ~gate_off[5:0];
      lp_ff <= drive_on[7:6] & ~gate_off[7:6];
    end
  end

  // Sticky fault register, frozen while selected, cleared by the read
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      fault_ff <= FAULT_NONE;
    end
    else if (st_ff == LSS_IDLE)
    begin
      fault_ff <= fault_ff | qual;
    end
    else if (cs_rise)
    begin
      fault_ff <= qual;
    end
  end

  assign high_power_outputs = hp_ff;
  assign low_power_outputs = lp_ff;
  assign so = so_ff;
  assign so_oe_n = so_oe_n_ff;
  assign fault_status = fault_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_so_release_mode: assert property (mode_f |=> so_oe_n_ff)
    else $error("serial output driven under override");
  a_lp_forced_off: assert property (mode_f |=> low_power_outputs == 2'h0)
    else $error("low power outputs on under override");
  a_or_control: assert property (!mode_f && gate_off[5:0] == 6'h00 |=>
      hp_ff == $past(cmd_ff.chan | par_pins[5:0]))
    else $error("high power outputs not from command or pins");
  a_lp_parallel: assert property (!mode_f && gate_off[7:6] == 2'h0 |=>
      lp_ff == $past(par_pins[7:6]))
    else $error("low power outputs not from their pins");
  a_fault_frozen: assert property ((st_ff == LSS_SEL && !cs_rise) |=> $stable(fault_ff))
    else $error("fault register changed during transfer");
  a_cmd_latched: assert property (cs_rise && st_ff == LSS_SEL |=>
      hold_v_ff && hold_cmd_ff == $past(rx_word))
    else $error("received command not captured at select release");
  a_status_msb: assert property ((st_ff == LSS_IDLE && cs_fall) |=>
      so_ff == $past(fault_ff[MSB_POS]) && shreg_ff == $past(fault_ff))
    else $error("status not loaded at select");
  a_fault_sticky: assert property (st_ff == LSS_IDLE |=>
      (fault_ff & $past(fault_ff)) == $past(fault_ff))
    else $error("fault bit dropped before readout");
  a_retry_off: assert property (|gate_off[5:0] |=>
      (high_power_outputs & $past(gate_off[5:0])) == 6'h00)
    else $error("output on during short retry wait");
  a_mode_pairs: assert property (mode_f && gate_off == 8'h00 |=>
      high_power_outputs == $past(par_pins[5:0]))
    else $error("override pairs not following pins");

  c_transfer_done: cover property (st_ff == LSS_SEL && cs_rise);
  c_override_write: cover property (mode_f && st_ff == LSS_SEL && cs_rise);
  c_queue_full: cover property (hold_v_ff && !fifo_in_ready);
  c_fault_seen: cover property (|qual);
endmodule : lss_spi_switch

// ---- testbench/lss_host_model.sv ----
`timescale 1ns/1ps
module lss_host_model (
  input wire logic clk,
  input wire logic so,
  input wire logic so_oe_n,
  output logic cs_n,
  output logic sclk,
  output logic si,
  output logic mode_ovr,
  output logic [7:0] parallel_input_pins
);
  logic so_w;
  // Released line reads high through the pull-up
  assign so_w = so_oe_n ? 1'b1 : so;
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
    mode_ovr = 1'b0;
    parallel_input_pins = 8'h00;
  end
  task automatic set_lines(input logic m, input logic [7:0] p);
    @(negedge clk);
    mode_ovr = m;
    parallel_input_pins = p;
  endtask : set_lines
  // Shifts n bits of tx from bit 31 down, collects so into rx
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0000_0000;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (8) @(negedge clk);
    for (int i = 0; i < n; i++)
    begin
      si = tx[31 - i];
      repeat (2) @(negedge clk);
      sclk = 1'b1;
      repeat (3) @(negedge clk);
      rx = {rx[30:0], so_w};
      @(negedge clk);
      sclk = 1'b0;
      repeat (2) @(negedge clk);
    end
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    si = 1'b0;
    repeat (12) @(negedge clk);
  endtask : xfer
endmodule : lss_host_model

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
  localparam int SENSE = 4;
  localparam int REFR = 8;
  logic clk;
  logic reset_n;
  logic cs_n;
  logic sclk;
  logic si;
  logic mode_ovr;
  logic so;
  logic so_oe_n;
  logic [7:0] pins;
  logic [7:0] short_sense;
  logic [7:0] open_sense;
  logic [7:0] fault_status;
  logic [5:0] hpo;
  logic [1:0] lpo;
  logic [31:0] rx;
  int n_errors = 0;
  int checks_done = 0;
  int on_cnt;

  lss_spi_switch #(.SENSE_CYC(SENSE), .REFRESH_CYC(REFR)) lss_spi_switch_i (
    .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk), .si(si), .mode_ovr(mode_ovr),
    .parallel_input_pins(pins), .short_sense(short_sense), .open_sense(open_sense),
    .high_power_outputs(hpo), .low_power_outputs(lpo), .so(so), .so_oe_n(so_oe_n),
    .fault_status(fault_status)
  );
  lss_host_model lss_host_model_i (
    .clk(clk), .so(so), .so_oe_n(so_oe_n), .cs_n(cs_n), .sclk(sclk), .si(si),
    .mode_ovr(mode_ovr), .parallel_input_pins(pins)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task final_report;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  task chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_word

  task chk_out(input logic [7:0] exp, input string msg);
    chk_word({24'h00_0000, lpo, hpo}, {24'h00_0000, exp}, msg);
  endtask : chk_out

  task wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  task t_reset;
    chk_out(8'h00, "outputs after reset");
    chk_word({31'h0000_0000, so_oe_n}, 32'h0000_0001, "so released");
    $display("test reset done");
  endtask : t_reset

  task t_cmd8;
    lss_host_model_i.xfer(8, 32'h2a00_0000, rx);
    wait_clk(15);
    chk_word(rx, 32'h0000_0000, "clean status");
    chk_out(8'h2a, "serial command");
    lss_host_model_i.set_lines(1'b0, 8'hc1);
    wait_clk(10);
    chk_out(8'heb, "serial or parallel");
    lss_host_model_i.set_lines(1'b0, 8'h00);
    $display("test cmd8 done");
  endtask : t_cmd8

  task t_cmd16;
    lss_host_model_i.xfer(16, 32'h1533_0000, rx);
    wait_clk(15);
    chk_word(rx, 32'h0000_0015, "status then first byte");
    chk_out(8'h33, "second byte latched");
    $display("test cmd16 done");
  endtask : t_cmd16

  task t_fault;
    open_sense[2] = 1'b1;
    wait_clk(2);
    open_sense[2] = 1'b0;
    wait_clk(12);
    chk_word({24'h00_0000, fault_status}, 32'h0000_0000, "transient ignored");
    short_sense[1] = 1'b1;
    open_sense[7] = 1'b1;
    wait_clk(15);
    chk_word({24'h00_0000, fault_status}, 32'h0000_0082, "faults seen");
    on_cnt = 0;
    repeat (24)
    begin
      @(negedge clk);
      on_cnt += int'(hpo[1]);
    end
    chk_word(32'(on_cnt < 12), 32'h0000_0001, "short retry duty");
    short_sense[1] = 1'b0;
    open_sense[7] = 1'b0;
    wait_clk(25);
    chk_word({24'h00_0000, fault_status}, 32'h0000_0082, "sticky faults");
    chk_out(8'h33, "output resumed");
    fork
      lss_host_model_i.xfer(8, 32'h3300_0000, rx);
      begin
        wait_clk(12);
        open_sense[3] = 1'b1;
        wait_clk(30);
        chk_word({24'h00_0000, fault_status}, 32'h0000_0082, "frozen");
      end
    join
    chk_word(rx, 32'h0000_0082, "status byte order");
    wait_clk(10);
    chk_word({24'h00_0000, fault_status}, 32'h0000_0008, "reopened");
    open_sense[3] = 1'b0;
    lss_host_model_i.xfer(8, 32'h7300_0000, rx);
    chk_word(rx, 32'h0000_0008, "sticky bit read");
    open_sense[0] = 1'b1;
    wait_clk(15);
    chk_word({24'h00_0000, fault_status}, 32'h0000_0001, "open while on");
    open_sense[0] = 1'b0;
    $display("test fault done");
  endtask : t_fault

  task t_override;
    logic [7:0] cmd;
    lss_host_model_i.set_lines(1'b1, 8'hd5);
    wait_clk(10);
    chk_out(8'h15, "override pins");
    for (int i = 0; i < 17; i++)
    begin
      cmd = 8'(i + 1);
      lss_host_model_i.xfer(8, {cmd, 24'h00_0000}, rx);
      chk_word(rx, 32'h0000_00ff, "so released");
    end
    chk_out(8'h15, "serial ignored");
    lss_host_model_i.set_lines(1'b0, 8'h00);
    wait_clk(60);
    chk_out(8'h11, "queued command applied");
    $display("test override done");
  endtask : t_override

  initial
  begin
    reset_n = 1'b0;
    short_sense = 8'h00;
    open_sense = 8'h00;
    wait_clk(10);
    reset_n = 1'b1;
    wait_clk(10);
    t_reset();
    t_cmd8();
    t_cmd16();
    t_fault();
    t_override();
    final_report();
  end

  initial
  begin
    repeat (10000) @(posedge clk);
    n_errors++;
    $display("wrong value at %0t: run timed out", $time);
    final_report();
  end
endmodule : tb
